// File: sfp_cfg.svh
// Purpose: constants of the serial command interface of the diagnosis block
// Assumes: 16-bit frames, bit 15 first, 200 MHz system clock
// Notes: definitions only
//
// Summary of operation
// - reply to a command is shifted out during the next frame
// - frame valid only with a multiple of 8 and at least 16 clocks
// - first reply after supply reset is the diagnosis word
// - unused or reserved register address answers with the diagnosis word
// - bit 15 write/read, bit 14 bank, address, data in bits 7..0
// - read sends bit 0 low; bit 15 low with bit 0 high asks diagnosis
// - register content reply has msb high, diagnosis reply msb low
// - second frame of a read is decoded as a normal command
// - reset, error and undervoltage flags are sticky, cleared by a diagnosis read
// - overheat shutdown stays latched until the latch-clear command
// - state field and overheat warning are live, not latched
// - routine done bits mirror internal bits; channel fault bits hold the latched overvoltage
// - latch-clear resets latched flags and protections and restarts switching
// - active state without routines or faults reads 1000 hex
// - diagnosis word layout from bit 15 down to bit 0
// - serial input captured on falling serial clock edges
// - serial output released when chip select returns high
// - state field: 01 limp home, 10 active, 11 idle, 00 reserved
// - routine done mirror follows channel of last start command
// - channel fault is or of shorted led, open load, overvoltage
// - serial output driven after chip select falls
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

`define SFP_FRAME_W 16
`define SFP_BYTE_W 8
`define SFP_WR_BIT 15
`define SFP_BANK_BIT 14
`define SFP_ADDR_HI 13
`define SFP_ADDR_LO 8
`define SFP_ADDR_W 6
`define SFP_DIAG_REQ_BIT 0
`define SFP_CNT_W 8
`define SFP_CNT_MIN 8'h10
`define SFP_FIFO_DEPTH 8
`define SFP_PIN_RST_VAL 3'h4
`define SFP_LATCH_CLR_ADDR 6'h3f
`define SFP_LATCH_CLR_BANK 1'b1
`define SFP_STATE_RSVD 2'h0
`define SFP_STATE_LIMP 2'h1
`define SFP_STATE_ACTIVE 2'h2
`define SFP_STATE_IDLE 2'h3
`define SFP_DIAG_IDLE_VALUE 16'h1000

`endif

// File: sfp_pkg.sv
// Purpose: shared types of the serial command interface
// Assumes: sfp_cfg.svh constants
// Notes: types only
`default_nettype none
`include "sfp_cfg.svh"
package sfp_pkg;
    typedef struct packed {
        logic write;
        logic bank;
        logic [`SFP_ADDR_W-1:0] addr;
        logic [`SFP_BYTE_W-1:0] data;
    } sfp_frame_t;

    typedef enum logic [1:0] {
        SFP_OP_RSVD = 2'h0,
        SFP_OP_LIMP = 2'h1,
        SFP_OP_ACTIVE = 2'h2,
        SFP_OP_IDLE = 2'h3
    } sfp_op_state_t;

    typedef enum logic [1:0] {
        SFP_EX_IDLE = 2'h0,
        SFP_EX_ISSUE = 2'h1,
        SFP_EX_CAPTURE = 2'h2
    } sfp_exec_t;

    typedef struct packed {
        logic soft_reset_seen_flag;
        logic supply_low_reset_flag;
        logic frame_error_flag;
        logic [1:0] gate_supply_low;
        logic regulator_low_flag;
    } sfp_sticky_t;
endpackage
`default_nettype wire

// File: sfp_sync.sv
// Purpose: three-stage input filter for pins from another clock domain
// Assumes: inputs change slower than two system clocks
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module sfp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output var logic [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // s1 feeds only s2: no logic may see a possibly metastable stage
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    q_o[g] <= RST_VAL[g];
                end else if (s2[g] == s3[g]) begin
                    q_o[g] <= s3[g];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: sfp_fifo.sv
// Purpose: small frame buffer between the link and the command executor
// Assumes: one push and one pop per clock at most
// Notes: flip-flop storage, honest full and empty
`timescale 1ns/100ps
`default_nettype none
module sfp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// File: sfp_diag_link.sv
// Purpose: serial command interpreter with diagnosis word and latch clear
// Assumes: serial clock idles low, data sampled on falling edges
// Notes: register file lives outside, answers a read in the strobe cycle
`timescale 1ns/100ps
`default_nettype none
`include "sfp_cfg.svh"
module sfp_diag_link (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CHIP_SELECT_LOW_N_I,
    input wire logic SCLK_I,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic SDO_OE_O,
    input wire logic SOFT_RESET_I,
    input wire logic [1:0] GATE_SUPPLY_LOW_I,
    input wire logic REGULATOR_LOW_I,
    input wire logic [1:0] OP_STATE_I,
    input wire logic OVERHEAT_WARNING_I,
    input wire logic OVERHEAT_SHUTDOWN_I,
    input wire logic [1:0] MON_DONE_I,
    input wire logic [1:0] FS_DONE_I,
    input wire logic [1:0] CAL_DONE_I,
    input wire logic [2:0] ROUTINE_CHAN_I,
    input wire logic [1:0] SHORTED_LED_I,
    input wire logic [1:0] OPEN_LOAD_I,
    input wire logic [1:0] OUTPUT_OVERVOLTAGE_I,
    input wire logic REG_BUSY_I,
    input wire logic REG_HIT_I,
    input wire logic [`SFP_BYTE_W-1:0] REG_RDATA_I,
    output logic REG_WR_O,
    output logic REG_RD_O,
    output logic REG_BANK_O,
    output logic [`SFP_ADDR_W-1:0] REG_ADDR_O,
    output logic [`SFP_BYTE_W-1:0] REG_WDATA_O,
    output logic LATCH_CLEAR_O,
    output logic SWITCH_HALT_O
);
    // ********************************************************
    // pin filtering and edge finding
    // ********************************************************
    logic cs_n;
    logic sclk;
    logic sdi;
    logic cs_n_d;
    logic sclk_d;

    sfp_sync #(.W(3), .RST_VAL(`SFP_PIN_RST_VAL)) u_sync (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .d_i({CHIP_SELECT_LOW_N_I, SCLK_I, SDI_I}),
        .q_o({cs_n, sclk, sdi})
    );

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cs_n_d <= 1'b1;
            sclk_d <= 1'b0;
        end else begin
            cs_n_d <= cs_n;
            sclk_d <= sclk;
        end
    end

    logic frame_start;
    logic frame_end;
    logic sclk_rise;
    logic sclk_fall;
    assign frame_start = cs_n_d && !cs_n;
    assign frame_end = !cs_n_d && cs_n;
    assign sclk_rise = !cs_n && !sclk_d && sclk;
    assign sclk_fall = !cs_n && sclk_d && !sclk;

    // ********************************************************
    // receive shifter and length check
    // ********************************************************
    logic [`SFP_FRAME_W-1:0] rx_shift;
    logic [`SFP_CNT_W-1:0] bit_cnt;
    logic enough_bits;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rx_shift <= '0;
            bit_cnt <= '0;
            enough_bits <= 1'b0;
        end else if (frame_start) begin
            bit_cnt <= '0;
            enough_bits <= 1'b0;
        end else if (sclk_fall) begin
            rx_shift <= {rx_shift[`SFP_FRAME_W-2:0], sdi};
            bit_cnt <= bit_cnt + 1'b1;
            // counter wraps on long frames; remember the minimum was reached
            if (bit_cnt + 1'b1 >= `SFP_CNT_MIN) begin
                enough_bits <= 1'b1;
            end
        end
    end

    logic frame_ok;
    assign frame_ok = enough_bits && (bit_cnt[2:0] == 3'h0);

    // ********************************************************
    // frame buffer toward the executor
    // ********************************************************
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    sfp_pkg::sfp_frame_t fifo_out;
    sfp_pkg::sfp_exec_t ex_state;
    logic push_frame;

    // a frame that finds the buffer full is dropped like a bad frame
    assign push_frame = frame_end && frame_ok;
    assign fifo_pop = (ex_state == sfp_pkg::SFP_EX_IDLE) && !REG_BUSY_I;

    sfp_fifo #(.WIDTH(`SFP_FRAME_W), .DEPTH(`SFP_FIFO_DEPTH)) u_fifo (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .in_valid_i(push_frame),
        .in_ready_o(fifo_in_ready),
        .in_data_i(rx_shift),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out)
    );

    // ********************************************************
    // flags and diagnosis word
    // ********************************************************
    sfp_pkg::sfp_sticky_t sticky;
    logic overheat_shutdown_flag;
    logic [1:0] output_overvoltage_flags;
    logic diag_read;
    logic latch_clear_command;
    logic frame_refused;

    assign frame_refused = frame_end && (!frame_ok || !fifo_in_ready);

    // set wins over the read-clear so an event in the clearing cycle survives
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sticky <= '0;
            sticky.supply_low_reset_flag <= 1'b1;
        end else begin
            sticky.soft_reset_seen_flag <= (sticky.soft_reset_seen_flag && !diag_read) || SOFT_RESET_I;
            sticky.supply_low_reset_flag <= sticky.supply_low_reset_flag && !diag_read;
            sticky.frame_error_flag <= (sticky.frame_error_flag && !diag_read) || frame_refused;
            sticky.gate_supply_low <= (sticky.gate_supply_low & {2{!diag_read}}) | GATE_SUPPLY_LOW_I;
            sticky.regulator_low_flag <= (sticky.regulator_low_flag && !diag_read) || REGULATOR_LOW_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            overheat_shutdown_flag <= 1'b0;
            output_overvoltage_flags <= '0;
        end else begin
            overheat_shutdown_flag <= (overheat_shutdown_flag && !latch_clear_command)
                || OVERHEAT_SHUTDOWN_I;
            output_overvoltage_flags <= (output_overvoltage_flags & {2{!latch_clear_command}})
                | OUTPUT_OVERVOLTAGE_I;
        end
    end

    logic [1:0] op_state;
    always_comb begin
        case (OP_STATE_I)
            `SFP_STATE_LIMP: op_state = sfp_pkg::SFP_OP_LIMP;
            `SFP_STATE_ACTIVE: op_state = sfp_pkg::SFP_OP_ACTIVE;
            `SFP_STATE_IDLE: op_state = sfp_pkg::SFP_OP_IDLE;
            default: op_state = sfp_pkg::SFP_OP_RSVD;
        endcase
    end

    logic [1:0] channel_fault;
    logic [`SFP_FRAME_W-1:0] diagnosis_word;
    assign channel_fault = SHORTED_LED_I | OPEN_LOAD_I | output_overvoltage_flags;

    // quiet active device gives 16'h1000 here
    assign diagnosis_word = {
        1'b0,
        sticky.soft_reset_seen_flag,
        sticky.supply_low_reset_flag,
        op_state,
        sticky.frame_error_flag,
        MON_DONE_I[ROUTINE_CHAN_I[2]],
        FS_DONE_I[ROUTINE_CHAN_I[1]],
        CAL_DONE_I[ROUTINE_CHAN_I[0]],
        sticky.gate_supply_low[1],
        sticky.gate_supply_low[0],
        sticky.regulator_low_flag,
        channel_fault[1],
        channel_fault[0],
        overheat_shutdown_flag,
        OVERHEAT_WARNING_I
    };

    // ********************************************************
    // command executor
    // ********************************************************
    sfp_pkg::sfp_frame_t cmd;
    logic cmd_is_read;
    logic cmd_is_diag;
    logic cmd_is_clear;

    assign cmd_is_diag = !fifo_out.write && fifo_out.data[`SFP_DIAG_REQ_BIT];
    assign cmd_is_read = !fifo_out.write && !cmd_is_diag;
    assign cmd_is_clear = fifo_out.write && (fifo_out.bank == `SFP_LATCH_CLR_BANK)
        && (fifo_out.addr == `SFP_LATCH_CLR_ADDR);

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ex_state <= sfp_pkg::SFP_EX_IDLE;
            cmd <= '0;
        end else begin
            case (ex_state)
                sfp_pkg::SFP_EX_IDLE: begin
                    if (fifo_pop && fifo_out_valid && cmd_is_read) begin
                        cmd <= fifo_out;
                        ex_state <= sfp_pkg::SFP_EX_ISSUE;
                    end
                end
                sfp_pkg::SFP_EX_ISSUE: begin
                    ex_state <= sfp_pkg::SFP_EX_CAPTURE;
                end
                sfp_pkg::SFP_EX_CAPTURE: begin
                    ex_state <= sfp_pkg::SFP_EX_IDLE;
                end
                default: begin
                    ex_state <= sfp_pkg::SFP_EX_IDLE;
                end
            endcase
        end
    end

    logic popped;
    assign popped = fifo_pop && fifo_out_valid;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            REG_WR_O <= 1'b0;
            REG_RD_O <= 1'b0;
            REG_BANK_O <= 1'b0;
            REG_ADDR_O <= '0;
            REG_WDATA_O <= '0;
            LATCH_CLEAR_O <= 1'b0;
        end else begin
            REG_WR_O <= popped && fifo_out.write && !cmd_is_clear;
            REG_RD_O <= (ex_state == sfp_pkg::SFP_EX_ISSUE);
            LATCH_CLEAR_O <= popped && cmd_is_clear;
            if (popped) begin
                REG_BANK_O <= fifo_out.bank;
                REG_ADDR_O <= fifo_out.addr;
                REG_WDATA_O <= fifo_out.data;
            end
        end
    end

    assign latch_clear_command = LATCH_CLEAR_O;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            SWITCH_HALT_O <= 1'b0;
        end else begin
            // restart follows the clear once no fault is still present
            SWITCH_HALT_O <= overheat_shutdown_flag || (|output_overvoltage_flags);
        end
    end

    // ********************************************************
    // reply selection and transmit shifter
    // ********************************************************
    logic reply_is_reg;
    logic [`SFP_FRAME_W-1:0] reply_reg;
    logic [`SFP_FRAME_W-1:0] tx_shift;
    logic first_rise;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            reply_is_reg <= 1'b0;
            reply_reg <= '0;
        end else if (frame_end) begin
            reply_is_reg <= 1'b0;
        end else if (ex_state == sfp_pkg::SFP_EX_CAPTURE) begin
            reply_is_reg <= REG_HIT_I;
            reply_reg <= {1'b1, cmd.bank, cmd.addr, REG_RDATA_I};
        end
    end

    // clearing on load of the word that reports the flags
    assign diag_read = frame_start && !reply_is_reg;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tx_shift <= '0;
            first_rise <= 1'b0;
        end else if (frame_start) begin
            tx_shift <= reply_is_reg ? reply_reg : diagnosis_word;
            first_rise <= 1'b1;
        end else if (sclk_rise) begin
            first_rise <= 1'b0;
            // bit 15 is already out at the first rising edge
            if (!first_rise) begin
                tx_shift <= {tx_shift[`SFP_FRAME_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            SDO_O <= 1'b0;
            SDO_OE_O <= 1'b0;
        end else begin
            SDO_OE_O <= !cs_n;
            SDO_O <= !cs_n && tx_shift[`SFP_FRAME_W-1];
        end
    end
endmodule
`default_nettype wire

// File: sfp_diag_link_sva.sv
// Purpose: port-level checks of the serial diagnosis link
// Assumes: link pins pass a short input filter
// Notes: bound into sfp_diag_link
`timescale 1ns/100ps
`default_nettype none
module sfp_diag_link_chk (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CHIP_SELECT_LOW_N_I,
    input wire logic SCLK_I,
    input wire logic SDO_O,
    input wire logic SDO_OE_O,
    input wire logic OVERHEAT_SHUTDOWN_I,
    input wire logic REG_WR_O,
    input wire logic LATCH_CLEAR_O,
    input wire logic SWITCH_HALT_O
);
    // ****************
    // frame, latch clear and halt checks
    // ****************
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    sequence s_cs_idle;
        CHIP_SELECT_LOW_N_I [*8];
    endsequence
    sequence s_cs_busy;
        !CHIP_SELECT_LOW_N_I [*8];
    endsequence
    sequence s_quiet;
        (!SCLK_I && !CHIP_SELECT_LOW_N_I) [*8];
    endsequence
    property p_oe_off;
        s_cs_idle |-> !SDO_OE_O;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("serial out driven while deselected");
    property p_oe_on;
        s_cs_busy |-> SDO_OE_O;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("serial out not driven in frame");
    property p_sdo_idle;
        !SDO_OE_O |-> !SDO_O;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("serial out not parked low");
    // no rising link clock in the window, so the bit must hold
    property p_sdo_hold;
        s_quiet ##0 $past(SDO_OE_O) |-> $stable(SDO_O);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("serial out moved without clock rise");
    property p_lc_pulse;
        LATCH_CLEAR_O |=> !LATCH_CLEAR_O;
    endproperty
    a_lc_pulse: assert property (p_lc_pulse) else $error("latch clear longer than one cycle");
    property p_lc_no_wr;
        LATCH_CLEAR_O |-> !REG_WR_O;
    endproperty
    a_lc_no_wr: assert property (p_lc_no_wr) else $error("latch clear forwarded as write");
    property p_halt_hold;
        SWITCH_HALT_O && !LATCH_CLEAR_O && !$past(LATCH_CLEAR_O) && !$past(LATCH_CLEAR_O, 2)
            && !$past(LATCH_CLEAR_O, 3) |=> SWITCH_HALT_O;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt dropped without latch clear");
    property p_halt_set;
        OVERHEAT_SHUTDOWN_I [*3] |-> ##[1:8] SWITCH_HALT_O;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("shutdown did not halt switching");
endmodule
bind sfp_diag_link sfp_diag_link_chk u_chk (
    .CLK_I(CLK_I),
    .RESET_N_I(RESET_N_I),
    .CHIP_SELECT_LOW_N_I(CHIP_SELECT_LOW_N_I),
    .SCLK_I(SCLK_I),
    .SDO_O(SDO_O),
    .SDO_OE_O(SDO_OE_O),
    .OVERHEAT_SHUTDOWN_I(OVERHEAT_SHUTDOWN_I),
    .REG_WR_O(REG_WR_O),
    .LATCH_CLEAR_O(LATCH_CLEAR_O),
    .SWITCH_HALT_O(SWITCH_HALT_O)
);
`default_nettype wire

// File: sfp_host_model.sv
// Purpose: host end of the serial link, frames commands and collects replies
// Assumes: clock and data lines have pull-downs, select has a pull-up
// Notes: 48 ns link clock; data moves on rising edges, replies read late in the low phase
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model #(
    parameter int HALF_NS = 24
) (
    output logic cs_low_n_o,
    output logic sclk_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic [7:0] oe_miss_o
);
    initial begin
        cs_low_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        oe_miss_o = 8'h00;
    end
    // ****************
    // one frame of n clocks
    // ****************
    task automatic xfer(input logic [23:0] cmd, input int n, output logic [15:0] rsp);
        int i;
        rsp = 16'h0000;
        cs_low_n_o = 1'b0;
        #200;
        for (i = n - 1; i >= 0; i--) begin
            sclk_o = 1'b1;
            sdi_o = cmd[i];
            #HALF_NS;
            sclk_o = 1'b0;
            // reply bit lags the pin filter, so read just before the next rise
            #HALF_NS;
            if (i >= n - 16) begin
                // undriven output floats: show the inverse so a late enable shows up
                rsp = {rsp[14:0], sdo_oe_i ? sdo_i : !sdo_i};
            end
            if (sdo_oe_i !== 1'b1) begin
                oe_miss_o = oe_miss_o + 8'h01;
            end
        end
        sdi_o = 1'b0;
        #180;
        cs_low_n_o = 1'b1;
        #300;
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench of the serial diagnosis link
// Assumes: register file modelled here, address 3e unmapped
// Notes: replies are checked one frame late
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe, soft_rst, reg_low, warn, shutdown, busy;
    logic [1:0] gsl, op_state, mon, fs, cal, shrt, ovv, opl;
    logic [2:0] chan;
    logic wr, rd, bank, lc, halt;
    logic [5:0] addr;
    logic [7:0] wdata, oe_miss;
    logic [14:0] last_wr;
    int wr_n, lc_n, rd_n, n0, i, err_count, compares;
    sfp_host_model u_host (.cs_low_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe), .oe_miss_o(oe_miss));
    sfp_diag_link u_dut (.CLK_I(clk), .RESET_N_I(rst_n), .CHIP_SELECT_LOW_N_I(cs_n), .SCLK_I(sclk),
        .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .SOFT_RESET_I(soft_rst), .GATE_SUPPLY_LOW_I(gsl),
        .REGULATOR_LOW_I(reg_low), .OP_STATE_I(op_state), .OVERHEAT_WARNING_I(warn),
        .OVERHEAT_SHUTDOWN_I(shutdown), .MON_DONE_I(mon), .FS_DONE_I(fs), .CAL_DONE_I(cal),
        .ROUTINE_CHAN_I(chan), .SHORTED_LED_I(shrt), .OPEN_LOAD_I(opl), .OUTPUT_OVERVOLTAGE_I(ovv),
        .REG_BUSY_I(busy), .REG_HIT_I(addr != 6'h3e), .REG_RDATA_I({2'h2, addr}), .REG_WR_O(wr),
        .REG_RD_O(rd), .REG_BANK_O(bank), .REG_ADDR_O(addr), .REG_WDATA_O(wdata),
        .LATCH_CLEAR_O(lc), .SWITCH_HALT_O(halt));
    always @(posedge clk) begin
        if (wr) begin
            wr_n <= wr_n + 1;
            last_wr <= {bank, addr, wdata};
        end
        if (lc) begin
            lc_n <= lc_n + 1;
        end
        if (rd) begin
            rd_n <= rd_n + 1;
        end
    end
    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic fr(input logic [23:0] cmd, input int n, input logic [15:0] exp);
        logic [15:0] rsp;
        u_host.xfer(cmd, n, rsp);
        chk(rsp, exp);
        chk({15'h0, sdo_oe}, 16'h0);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic s_reset;
        fr(24'h0001, 16, 16'h3000);
        fr(24'h0001, 16, 16'h1000);
    endtask
    task automatic s_regs;
        n0 = rd_n;
        fr(24'h4500, 16, 16'h1000);
        fr(24'hc35a, 16, 16'hc585);
        chk(16'(last_wr), 16'h435a);
        fr(24'h3e00, 16, 16'h1000);
        fr(24'h0001, 16, 16'h1000);
        chk(16'(rd_n - n0), 16'h2);
    endtask
    task automatic s_err;
        n0 = wr_n;
        fr(24'h000fff, 12, 16'h0100);
        chk(16'(wr_n - n0), 16'h0);
        fr(24'h0001, 16, 16'h1400);
        fr(24'hff835a, 24, 16'h1000);
        chk(16'(wr_n - n0), 16'h1);
    endtask
    // stalled register file: eight frames fit, the ninth is refused
    task automatic s_fill;
        @(negedge clk);
        busy = 1'b1;
        n0 = wr_n;
        for (i = 0; i < 9; i++) begin
            fr(24'h008100 + 24'(i), 16, 16'h1000);
        end
        chk(16'(wr_n - n0), 16'h0);
        @(negedge clk);
        busy = 1'b0;
        for (i = 0; i < 100 && wr_n - n0 < 8; i++) begin
            @(negedge clk);
        end
        if (wr_n - n0 != 8) begin
            err_count++;
            $display("BAD t=%0t buffer drain timed out", $time);
            stop_test();
        end
        fr(24'h0001, 16, 16'h1400);
    endtask
    task automatic s_flags;
        @(negedge clk);
        soft_rst = 1'b1;
        gsl = 2'h3;
        reg_low = 1'b1;
        shutdown = 1'b1;
        ovv = 2'h1;
        warn = 1'b1;
        op_state = 2'h3;
        mon = 2'h2;
        fs = 2'h1;
        cal = 2'h1;
        chan = 3'h6;
        shrt = 2'h2;
        repeat (6) @(negedge clk);
        soft_rst = 1'b0;
        gsl = 2'h0;
        reg_low = 1'b0;
        shutdown = 1'b0;
        ovv = 2'h0;
        repeat (10) @(negedge clk);
        fr(24'h0001, 16, 16'h5aff);
        chk(16'(halt), 16'h1);
        fr(24'h0001, 16, 16'h1a8f);
        n0 = lc_n;
        fr(24'hff00, 16, 16'h1a8f);
        chk(16'(lc_n - n0), 16'h1);
        chk(16'(halt), 16'h0);
        @(negedge clk);
        op_state = 2'h1;
        warn = 1'b0;
        shrt = 2'h0;
        opl = 2'h2;
        fr(24'h0001, 16, 16'h0a88);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        {soft_rst, reg_low, warn, shutdown, busy} = 5'h00;
        {gsl, mon, fs, cal, shrt, ovv, opl} = 14'h0000;
        op_state = 2'h2;
        chan = 3'h0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        s_reset();
        s_regs();
        s_err();
        s_fill();
        s_flags();
        chk(16'(oe_miss), 16'h0);
        stop_test();
    end
endmodule
`default_nettype wire
